// file: tss_serial_slave.sv
// Serial slave, register pointer and register file of the temperature sensor
// Operation
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Mid-transfer START or STOP abandons, releases data
// - Acknowledge only address 0011 plus strap pins
// - Eighth address bit: one read, zero write
// - Receiver acknowledges every byte; master clocks it
// - Acknowledge low across whole acknowledge clock pulse
// - Master not acknowledging ends read; line released
// - Idle when both high; busy START to STOP
// - No auto-increment; one register per transaction
// - Pointer retained; bare read uses previous register
// - Clock stuck low or high resets interface
// - Slave only; never drives clock or conditions
// - Eight-bit pointer; only low four bits select
// - Pointer codes zero to eight decode fixed registers
// - Codes 1XXX above eight are hidden registers
// - Ambient reading read-only, loaded whole per conversion
// - High and low limits writable; drive alarm
// - Critical limit writable; extra alarm threshold
// - Time-out between 25 ms and 35 ms
`timescale 1ns/1ps

module tss_serial_slave
   import tss_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = BUS_TIMEOUT_CYC,
   parameter logic [15:0] MAKER_CODE = MAKER_CODE_DEF,
   parameter logic [15:0] PART_CODE = PART_CODE_DEF
)
(
   // System clock, reset and enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Serial bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Address strap pins
   input wire logic strapAddrBit0,
   input wire logic strapAddrBit1,
   input wire logic strapAddrBit2,
   // Converter side, on its own clock
   input wire logic convClk,
   input wire logic convRst_b,
   input wire logic convDone,
   input wire logic [15:0] convReading,
   // Status
   output logic alarmOut,
   output logic busBusy
);

   tss_sys_t r;
   tss_sys_t n;
   tss_conv_t c;
   tss_conv_t cn;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   logic timeoutEv;
   logic [7:0] nextTx;

   // Register read decode, shared by the address phase
   function automatic logic [15:0] regRead(input tss_sys_t s);
      logic [15:0] v;
      v = 16'h0000;
      unique case (s.regSelect)
         PTR_FEATURE: v = FEATURE_VALUE;
         PTR_SETUP: v = s.sensorSetup;
         PTR_HIGH: v = s.alarmHighLimit;
         PTR_LOW: v = s.alarmLowLimit;
         PTR_CRIT: v = s.alarmCriticalLimit;
         PTR_AMBIENT: v = {s.overCrit, s.overHigh, s.underLow, s.ambientTemp};
         PTR_MAKER: v = MAKER_CODE;
         PTR_PART: v = PART_CODE;
         PTR_RESOL: v = {s.conversionStepSelect, 8'h00}; // Single byte, sent first
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // Bus events from the synchronised pins; the first stage is never read here
   assign sclRise = r.sclSync & ~r.sclLast;
   assign sclFall = ~r.sclSync & r.sclLast;
   assign startEv = r.sclSync & r.sclLast & r.sdaLast & ~r.sdaSync;
   assign stopEv = r.sclSync & r.sclLast & ~r.sdaLast & r.sdaSync;
   assign timeoutEv = r.busy && (r.toCnt >= TO_CNT_W'(TIMEOUT_CYC - 1));

   // Next state of the system domain
   always_comb
   begin
      n = r;
      nextTx = 8'h00;
      n.sclMeta = sclIn;
      n.sclSync = r.sclMeta;
      n.sclLast = r.sclSync;
      n.sdaMeta = sdaIn;
      n.sdaSync = r.sdaMeta;
      n.sdaLast = r.sdaSync;
      n.strapMeta = {strapAddrBit2, strapAddrBit1, strapAddrBit0};
      n.strapSync = r.strapMeta;
      n.cvMeta = c.tgl;
      n.cvSync = r.cvMeta;
      n.cvLast = r.cvSync;

      // New conversion result: held stable in the other domain, load all bits at once
      if (r.cvSync != r.cvLast)
      begin
         n.ambientTemp = c.hold[TEMP_W-1:0];
      end

      // Limit comparisons on signed temperature
      n.overHigh = $signed(r.ambientTemp) > $signed(r.alarmHighLimit[TEMP_W-1:0]);
      n.underLow = $signed(r.ambientTemp) < $signed(r.alarmLowLimit[TEMP_W-1:0]);
      n.overCrit = $signed(r.ambientTemp) >= $signed(r.alarmCriticalLimit[TEMP_W-1:0]);

      // Time-out counter restarts on every clock edge and while idle
      if (!r.busy || sclRise || sclFall)
      begin
         n.toCnt = '0;
      end
      else
      begin
         n.toCnt = r.toCnt + TO_CNT_W'(1);
      end

      if (startEv)
      begin
         // Start or repeated start: drop everything, release data
         n.state = ST_ADDR;
         n.busy = 1'b1;
         n.bitCnt = 4'h0;
         n.sdaDrive = 1'b0;
      end
      else if (stopEv || timeoutEv)
      begin
         n.state = ST_IDLE;
         n.busy = 1'b0;
         n.bitCnt = 4'h0;
         n.sdaDrive = 1'b0;
      end
      else
      begin
         unique case (r.state)
            ST_IDLE:
            begin
               n.sdaDrive = 1'b0;
            end
            ST_ADDR:
            begin
               if (sclRise)
               begin
                  n.shReg = {r.shReg[6:0], r.sdaSync};
                  n.bitCnt = r.bitCnt + 4'h1;
               end
               if (sclFall && r.bitCnt == BYTE_BITS)
               begin
                  n.bitCnt = 4'h0;
                  n.byteIdx = 2'h0;
                  if (r.shReg[7:1] == {ADDR_PREFIX, r.strapSync})
                  begin
                     n.state = ST_ADDR_ACK;
                     n.sdaDrive = 1'b1;
                     n.isRead = r.shReg[0];
                     n.rdWord = regRead(r);
                  end
                  else
                  begin
                     n.state = ST_DONE;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               // Release or first data bit only after the acknowledge pulse falls
               if (sclFall)
               begin
                  if (r.isRead)
                  begin
                     n.state = ST_RD_BYTE;
                     n.txReg = r.rdWord[15:8];
                     n.sdaDrive = ~r.rdWord[15];
                  end
                  else
                  begin
                     n.state = ST_WR_BYTE;
                     n.sdaDrive = 1'b0;
                  end
               end
            end
            ST_WR_BYTE:
            begin
               if (sclRise)
               begin
                  n.shReg = {r.shReg[6:0], r.sdaSync};
                  n.bitCnt = r.bitCnt + 4'h1;
               end
               if (sclFall && r.bitCnt == BYTE_BITS)
               begin
                  n.bitCnt = 4'h0;
                  n.state = ST_WR_ACK;
                  n.sdaDrive = 1'b1;
                  if (r.byteIdx != BYTE_LAST)
                  begin
                     n.byteIdx = r.byteIdx + 2'h1;
                  end
                  unique case (r.byteIdx)
                     2'h0:
                     begin
                        n.regSelect = r.shReg[3:0];
                     end
                     2'h1:
                     begin
                        n.dataMsb = r.shReg;
                        if (r.regSelect == PTR_RESOL)
                        begin
                           n.conversionStepSelect = r.shReg & RESOL_MASK;
                        end
                     end
                     2'h2:
                     begin
                        // Whole word lands at once in the selected register
                        unique case (r.regSelect)
                           PTR_SETUP:
                           begin
                              n.sensorSetup = {r.dataMsb, r.shReg};
                           end
                           PTR_HIGH:
                           begin
                              n.alarmHighLimit = {r.dataMsb, r.shReg} & LIMIT_MASK;
                           end
                           PTR_LOW:
                           begin
                              n.alarmLowLimit = {r.dataMsb, r.shReg} & LIMIT_MASK;
                           end
                           PTR_CRIT:
                           begin
                              n.alarmCriticalLimit = {r.dataMsb, r.shReg} & LIMIT_MASK;
                           end
                           default:
                           begin
                              // Read-only and hidden codes ignore writes
                              n.dataMsb = r.dataMsb;
                           end
                        endcase
                     end
                     default:
                     begin
                        n.dataMsb = r.dataMsb;
                     end
                  endcase
               end
            end
            ST_WR_ACK:
            begin
               if (sclFall)
               begin
                  n.state = ST_WR_BYTE;
                  n.sdaDrive = 1'b0;
               end
            end
            ST_RD_BYTE:
            begin
               if (sclRise)
               begin
                  n.bitCnt = r.bitCnt + 4'h1;
               end
               if (sclFall)
               begin
                  if (r.bitCnt == BYTE_BITS)
                  begin
                     n.bitCnt = 4'h0;
                     n.state = ST_RD_ACK;
                     n.sdaDrive = 1'b0; // Master owns the acknowledge slot
                  end
                  else
                  begin
                     n.txReg = {r.txReg[6:0], 1'b0};
                     n.sdaDrive = ~r.txReg[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (sclRise && r.sdaSync)
               begin
                  n.state = ST_DONE;
               end
               else if (sclFall)
               begin
                  // Low byte after the high one, then zeros: no next register
                  nextTx = (r.byteIdx == 2'h0) ? r.rdWord[7:0] : 8'h00;
                  n.state = ST_RD_BYTE;
                  n.txReg = nextTx;
                  n.sdaDrive = ~nextTx[7];
                  if (r.byteIdx != BYTE_LAST)
                  begin
                     n.byteIdx = r.byteIdx + 2'h1;
                  end
               end
            end
            ST_DONE:
            begin
               n.sdaDrive = 1'b0;
            end
         endcase
      end
   end

   // System domain registers, frozen while the enable is low
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         r <= '0;
         r.sclMeta <= 1'b1;
         r.sclSync <= 1'b1;
         r.sclLast <= 1'b1;
         r.sdaMeta <= 1'b1;
         r.sdaSync <= 1'b1;
         r.sdaLast <= 1'b1;
         r.state <= ST_IDLE;
         r.regSelect <= PTR_RESET;
         r.sensorSetup <= SETUP_RESET;
         r.alarmHighLimit <= LIMIT_RESET;
         r.alarmLowLimit <= LIMIT_RESET;
         r.alarmCriticalLimit <= LIMIT_RESET;
         r.conversionStepSelect <= RESOL_RESET;
      end
      else if (clkEn)
      begin
         r <= n;
      end
   end

   // Converter domain: capture each finished result and flag it by a toggle
   always_comb
   begin
      cn = c;
      if (convDone)
      begin
         cn.hold = convReading;
         cn.tgl = ~c.tgl;
      end
   end

   // Converter domain registers
   always_ff @(posedge convClk)
   begin
      if (!convRst_b)
      begin
         c <= '0;
      end
      else
      begin
         c <= cn;
      end
   end

   // Open-drain data: only ever pulled low; the clock pin is input only
   assign sdaOut = 1'b0;
   assign sdaOe = r.sdaDrive;
   assign alarmOut = r.overHigh | r.underLow | r.overCrit;
   assign busBusy = r.busy;

endmodule // tss_serial_slave

// file: tss_pkg.sv
// Constants, state codes and state records for the temperature sensor serial slave
package tss_pkg;

   // Register selector codes (low nibble of the pointer)
   localparam logic [3:0] PTR_FEATURE = 4'h0;
   localparam logic [3:0] PTR_SETUP = 4'h1;
   localparam logic [3:0] PTR_HIGH = 4'h2;
   localparam logic [3:0] PTR_LOW = 4'h3;
   localparam logic [3:0] PTR_CRIT = 4'h4;
   localparam logic [3:0] PTR_AMBIENT = 4'h5;
   localparam logic [3:0] PTR_MAKER = 4'h6;
   localparam logic [3:0] PTR_PART = 4'h7;
   localparam logic [3:0] PTR_RESOL = 4'h8;
   localparam logic [3:0] PTR_RESET = 4'h0;

   // Fixed upper address bits of the sensor
   localparam logic [3:0] ADDR_PREFIX = 4'h3;

   // Register reset values and writable bit masks
   localparam logic [15:0] FEATURE_VALUE = 16'h00EF;
   localparam logic [15:0] SETUP_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
   localparam logic [7:0] RESOL_RESET = 8'h01;
   localparam logic [7:0] RESOL_MASK = 8'h03;
   // Arbitrary identification values
   localparam logic [15:0] MAKER_CODE_DEF = 16'h0A5A;
   localparam logic [15:0] PART_CODE_DEF = 16'h5A01;

   // Ambient reading layout: flag bits above a 13-bit signed temperature
   localparam int AMB_CRIT_BIT = 15;
   localparam int AMB_HIGH_BIT = 14;
   localparam int AMB_LOW_BIT = 13;
   localparam int TEMP_W = 13;

   // Bits per byte on the serial line
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Data byte index saturates here; later bytes are acknowledged and dropped
   localparam logic [1:0] BYTE_LAST = 2'h3;

   // Bus time-out: 30000 us lies inside the 25 ms to 35 ms window
   localparam int CLK_KHZ = 20000;
   localparam int BUS_TIMEOUT_US = 30000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * (CLK_KHZ / 1000);
   localparam int TO_CNT_W = 20;

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WR_BYTE = 3'b011,
      ST_WR_ACK = 3'b100,
      ST_RD_BYTE = 3'b101,
      ST_RD_ACK = 3'b110,
      ST_DONE = 3'b111
   } tss_state_t;

   // All state of the system clock domain
   typedef struct packed {
      logic sclMeta;
      logic sclSync;
      logic sclLast;
      logic sdaMeta;
      logic sdaSync;
      logic sdaLast;
      logic [2:0] strapMeta;
      logic [2:0] strapSync;
      logic cvMeta;
      logic cvSync;
      logic cvLast;
      tss_state_t state;
      logic busy;
      logic [3:0] bitCnt;
      logic [1:0] byteIdx;
      logic [7:0] shReg;
      logic [7:0] txReg;
      logic [15:0] rdWord;
      logic isRead;
      logic sdaDrive;
      logic [3:0] regSelect;
      logic [7:0] dataMsb;
      logic [15:0] sensorSetup;
      logic [15:0] alarmHighLimit;
      logic [15:0] alarmLowLimit;
      logic [15:0] alarmCriticalLimit;
      logic [7:0] conversionStepSelect;
      logic [TEMP_W-1:0] ambientTemp;
      logic overCrit;
      logic overHigh;
      logic underLow;
      logic [TO_CNT_W-1:0] toCnt;
   } tss_sys_t;

   // All state of the converter clock domain
   typedef struct packed {
      logic [15:0] hold;
      logic tgl;
   } tss_conv_t;

endpackage

// file: tss_props.sv
// Concurrent checks on the serial slave's ports
`timescale 1ns/1ps

module tss_props
   import tss_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = BUS_TIMEOUT_CYC
)
(
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Serial pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Status
   input wire logic alarmOut,
   input wire logic busBusy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b || !clkEn);

   logic sclPrev;
   logic [19:0] sclAge;

   // Cycles since the serial clock last moved, saturating
   always_ff @(posedge sys_clk)
   begin
      sclPrev <= sclIn;
      if (!rst_b || sclIn != sclPrev)
         sclAge <= 20'h00000;
      else if (sclAge != 20'hFFFFF)
         sclAge <= sclAge + 20'h00001;
   end

   a_only_low: assert property (sdaOe |-> sdaOut == 1'b0) else $error("data driven high");
   a_oe_scl_low: assert property ($changed(sdaOe) && busBusy |-> !sclIn)
      else $error("data moved with clock high");
   a_hold_high: assert property ($rose(sclIn) && busBusy |=> $stable(sdaOe) [*4])
      else $error("data moved during clock pulse");
   a_hold_after: assert property ($fell(sclIn) && busBusy |-> $stable(sdaOe) [*2])
      else $error("data released too soon");
   a_idle_free: assert property (!busBusy && !$past(busBusy) |-> !sdaOe)
      else $error("line driven while idle");
   a_start_busy: assert property (
      sclIn && $past(sclIn) && $fell(sdaIn) |-> ##[1:4] busBusy)
      else $error("start not seen");
   a_stop_idle: assert property (
      sclIn && $past(sclIn) && $rose(sdaIn) |-> ##[1:4] !busBusy)
      else $error("stop not seen");
   a_ack_busy: assert property ($rose(sdaOe) |-> busBusy && !sclIn)
      else $error("drive outside transfer");
   a_timeout_rel: assert property (
      sclAge == 20'(TIMEOUT_CYC + 8) |-> !busBusy && !sdaOe)
      else $error("time-out did not reset");

   // Main scenarios reached
   c_ack: cover property ($rose(sdaOe));
   c_stop: cover property ($fell(busBusy));
   c_alarm: cover property ($fell(alarmOut));
endmodule // tss_props

bind tss_serial_slave tss_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) tss_props_i (
   .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .alarmOut(alarmOut), .busBusy(busBusy)
);

// file: tss_master.sv
// Two-wire bus master model for the sensor's serial pins
`timescale 1ns/1ps

module tss_master
(
   // Clock and wire levels
   input wire logic sys_clk,
   input wire logic sdaOe,
   output logic scl,
   output logic sda
);
   logic mSda;

   // Wired-AND with pull-up; the device only pulls low
   assign sda = mSda & ~sdaOe;

   // Released bus at time zero
   initial
   begin
      mSda = 1'b1;
      scl = 1'b1;
   end

   // Waits n edges, then steps off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // One bit cell: data set mid low phase, sampled late in high phase
   task automatic bitx(input logic b, output logic r);
      tick(2);
      mSda = b;
      tick(3);
      scl = 1'b1;
      tick(5);
      r = sda;
      scl = 1'b0;
   endtask

   // Data falls with clock high, then clock goes low
   task automatic start();
      mSda = 1'b1;
      scl = 1'b1;
      tick(5);
      mSda = 1'b0;
      tick(5);
      scl = 1'b0;
   endtask

   // Data rises with clock high, then bus rests
   task automatic stop();
      tick(2);
      mSda = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(5);
      mSda = 1'b1;
      tick(10);
   endtask

   // Sends a byte MSB first and returns the acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(d[i], r);
      end
      bitx(1'b1, r);
      ack = ~r;
   endtask

   // Reads a byte; nak high marks the last one
   task automatic rbyte(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(nak, r);
   endtask
endmodule // tss_master

// file: temp_sensor_serial_slave_test.sv
// Self-checking bench for the temperature sensor serial slave
`timescale 1ns/1ps

module temp_sensor_serial_slave_test;
   import tss_pkg::*;
   localparam int TO_CYC = 200;
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [6:0] DEV = {ADDR_PREFIX[3:0], STRAP};
   logic sys_clk = 1'b0;
   logic convClk = 1'b0;
   logic rst_b = 1'b0;
   logic convRst_b = 1'b0;
   logic convDone = 1'b0;
   logic clkEn = 1'b1;
   logic [2:0] strap = STRAP;
   logic [15:0] convReading = 16'h0000;
   logic sclIn, sdaIn, sdaOut, sdaOe, alarmOut, busBusy, ack, r;
   logic [15:0] word;
   logic [3:0] roPtr [3] = '{PTR_FEATURE, PTR_MAKER, PTR_PART};
   logic [15:0] roVal [3] = '{FEATURE_VALUE, MAKER_CODE_DEF, PART_CODE_DEF};
   logic [6:0] badMask [4] = '{7'h01, 7'h02, 7'h04, 7'h40};
   int bad_count = 0;
   int tests_run = 0;
   int n;

   // Clocks of the two domains
   always #25 sys_clk = ~sys_clk;
   always #24 convClk = ~convClk;

   tss_serial_slave #(.TIMEOUT_CYC(TO_CYC)) tss_serial_slave_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .strapAddrBit0(strap[0]), .strapAddrBit1(strap[1]),
      .strapAddrBit2(strap[2]), .convClk(convClk), .convRst_b(convRst_b),
      .convDone(convDone), .convReading(convReading), .alarmOut(alarmOut), .busBusy(busBusy)
   );
   tss_master tss_master_i (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(sclIn), .sda(sdaIn));

   // Compares and counts
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Pointer write followed by k data bytes, MSB first
   task automatic wr(input logic [3:0] ptr, input logic [15:0] d, input int k);
      tss_master_i.start();
      tss_master_i.wbyte({DEV, 1'b0}, ack);
      chk(16'(ack), 16'h0001);
      tss_master_i.wbyte({4'h0, ptr}, ack);
      if (k > 0)
         tss_master_i.wbyte(d[15:8], ack);
      if (k > 1)
         tss_master_i.wbyte(d[7:0], ack);
      tss_master_i.stop();
   endtask

   // Bare read of the selected register
   task automatic rd(output logic [15:0] d);
      tss_master_i.start();
      tss_master_i.wbyte({DEV, 1'b1}, ack);
      chk(16'(ack), 16'h0001);
      tss_master_i.rbyte(1'b0, d[15:8]);
      tss_master_i.rbyte(1'b1, d[7:0]);
      tss_master_i.tick(4);
      chk(16'(sdaOe), 16'h0000);
      tss_master_i.stop();
   endtask

   // Prints the verdict and ends the run
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      convRst_b = 1'b1;
      tss_master_i.tick(4);
      chk(16'(busBusy), 16'h0000);
      // Frozen engine must not see a start on the pins
      clkEn = 1'b0;
      tss_master_i.start();
      tss_master_i.tick(4);
      chk(16'(busBusy), 16'h0000);
      clkEn = 1'b1;
      tss_master_i.stop();
      for (int i = 0; i < 3; i++)
      begin
         wr(roPtr[i], 16'h1234, 2);
         rd(word);
         chk(word, roVal[i]);
      end
      wr(PTR_HIGH, 16'h07FF, 2);
      rd(word);
      chk(word, 16'h07FF & LIMIT_MASK);
      wr(PTR_SETUP, 16'hA5C3, 2);
      rd(word);
      chk(word, 16'hA5C3);
      wr(PTR_RESOL, 16'hFF00, 2);
      rd(word);
      chk(word, {8'hFF & RESOL_MASK, 8'h00});
      wr(PTR_LOW, 16'h0100, 2);
      // Abandoned write of the high limit
      tss_master_i.start();
      tss_master_i.wbyte({DEV, 1'b0}, ack);
      tss_master_i.wbyte({4'h0, PTR_HIGH}, ack);
      tss_master_i.wbyte(8'h01, ack);
      for (int i = 0; i < 4; i++)
         tss_master_i.bitx(1'b0, r);
      tss_master_i.stop();
      wr(PTR_HIGH, 16'h0000, 0);
      rd(word);
      chk(word, 16'h07FC);
      rd(word);
      chk(word, 16'h07FC);
      for (int i = 0; i < 4; i++)
      begin
         tss_master_i.start();
         tss_master_i.wbyte({DEV ^ badMask[i], 1'b0}, ack);
         chk(16'(ack), 16'h0000);
         tss_master_i.stop();
      end
      // One conversion result crosses from the converter clock
      @(posedge convClk);
      #1;
      convDone = 1'b1;
      convReading = 16'hE190;
      @(posedge convClk);
      #1;
      convDone = 1'b0;
      tss_master_i.tick(10);
      wr(PTR_AMBIENT, 16'h0000, 2);
      rd(word);
      chk(word, 16'h8190);
      chk(16'(alarmOut), 16'h0001);
      wr(PTR_CRIT, 16'h0500, 2);
      tss_master_i.tick(4);
      chk(16'(alarmOut), 16'h0000);
      // Clock held low after the address acknowledge
      tss_master_i.start();
      tss_master_i.wbyte({DEV, 1'b0}, ack);
      chk(16'(busBusy), 16'h0001);
      n = 0;
      while (busBusy && n < TO_CYC + 50)
      begin
         tss_master_i.tick(1);
         n++;
      end
      chk(16'(busBusy), 16'h0000);
      if (!busBusy)
         tss_master_i.stop();
      report_and_stop();
   end
endmodule // temp_sensor_serial_slave_test
